// *** rtl/exec_pkg.sv ***
// Function
// RQ1 - Subroutine exit loads counter from stack.
// RQ2 - Literal exit pops counter, loads literal.
// RQ3 - Interrupt exit pops counter, sets enable.
// RQ4 - Rotate left, bit 7 to 0, write back.
// RQ5 - Rotate left into working register only.
// RQ6 - Left through carry, write memory back.
// RQ7 - Left through carry into working register.
// RQ8 - Rotate right, bit 0 to 7, write back.
// RQ9 - Rotate right into working register only.
// RQ10 - Right through carry, write memory back.
// RQ11 - Only through-carry rotates touch any flag.
package exec_pkg;

    // Program counter width; a 3K word program store needs twelve bits.
    localparam int PC_WIDTH = 12;
    localparam int DATA_WIDTH = 8;
    localparam int MSB_POS = 7;
    localparam int LSB_POS = 0;

    // Operation codes handed over by the instruction decoder.
    typedef enum logic [3:0] {
        OP_IDLE = 4'h0,
        OP_SUBROUTINE_EXIT = 4'h1,
        OP_SUBROUTINE_EXIT_WITH_LITERAL = 4'h2,
        OP_INTERRUPT_EXIT = 4'h3,
        OP_ROTATE_LEFT_IN_PLACE = 4'h4,
        OP_ROTATE_LEFT_TO_ACCUMULATOR = 4'h5,
        OP_ROTATE_LEFT_THROUGH_CARRY = 4'h6,
        OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR = 4'h7,
        OP_ROTATE_RIGHT_IN_PLACE = 4'h8,
        OP_ROTATE_RIGHT_TO_ACCUMULATOR = 4'h9,
        OP_ROTATE_RIGHT_THROUGH_CARRY = 4'ha
    } op_t;

    // Everything the core presents with one operation.
    typedef struct packed {
        op_t op;
        logic [DATA_WIDTH-1:0] imm;
        logic [DATA_WIDTH-1:0] mem_data;
        logic carry;
        logic [PC_WIDTH-1:0] stack_top;
    } exec_req_t;

    // Everything the slice drives back into the core.
    typedef struct packed {
        logic done;
        logic illegal;
        logic pc_load;
        logic [PC_WIDTH-1:0] pc;
        logic stack_pop;
        logic gie_set;
        logic wreg_we;
        logic [DATA_WIDTH-1:0] wreg;
        logic mem_we;
        logic [DATA_WIDTH-1:0] mem_wdata;
        logic carry_we;
        logic carry;
    } exec_res_t;

    // Values after reset.
    localparam logic [PC_WIDTH-1:0] PC_RESET = 12'h000;
    localparam logic [DATA_WIDTH-1:0] BYTE_RESET = 8'h00;

endpackage

// *** rtl/byte_rotator.sv ***
`timescale 1ns/100ps
// One-position byte rotation, optionally through a ninth carry bit.
module byte_rotator
    import exec_pkg::*;
(
    input wire logic [DATA_WIDTH-1:0] data_i,
    input wire logic carry_i,
    input wire logic left_i,
    input wire logic thru_carry_i,
    output logic [DATA_WIDTH-1:0] data_o,
    output logic carry_o
);

    logic in_bit;

    // The bit entering the byte is either the wrapped bit or old carry.
    always_comb begin
        if (left_i) begin
            in_bit = thru_carry_i ? carry_i : data_i[MSB_POS]; // RQ4 RQ6
            data_o = {data_i[MSB_POS-1:LSB_POS], in_bit};
            carry_o = data_i[MSB_POS]; // RQ6
        end else begin
            in_bit = thru_carry_i ? carry_i : data_i[LSB_POS]; // RQ8 RQ10
            data_o = {in_bit, data_i[MSB_POS:LSB_POS+1]};
            carry_o = data_i[LSB_POS]; // RQ10
        end
    end

endmodule // byte_rotator

// *** rtl/return_and_rotate_exec.sv ***
`timescale 1ns/100ps
// Execution slice for the return group and the single-bit rotates.
module return_and_rotate_exec
    import exec_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic op_valid_i,
    input wire exec_req_t op_req_i,
    output exec_res_t res_o
);

    logic is_return;
    logic is_rotate;
    logic rot_left;
    logic rot_thru;
    logic rot_to_wreg;
    logic known_op;
    logic [DATA_WIDTH-1:0] rot_data;
    logic rot_carry;

    logic done_q;
    logic illegal_q;
    logic pc_load_q;
    logic [PC_WIDTH-1:0] pc_q;
    logic stack_pop_q;
    logic gie_set_q;
    logic wreg_we_q;
    logic [DATA_WIDTH-1:0] wreg_q;
    logic mem_we_q;
    logic [DATA_WIDTH-1:0] mem_wdata_q;
    logic carry_we_q;
    logic carry_q;

    // Classify the operation once so every process sees the same view.
    always_comb begin
        is_return = 1'b0;
        is_rotate = 1'b0;
        rot_left = 1'b0;
        rot_thru = 1'b0;
        rot_to_wreg = 1'b0;
        known_op = 1'b1;
        unique case (op_req_i.op)
            // Idle is legal but completes nothing, so it gives no done pulse.
            OP_IDLE: begin
                known_op = 1'b1;
            end
            OP_SUBROUTINE_EXIT,
            OP_SUBROUTINE_EXIT_WITH_LITERAL,
            OP_INTERRUPT_EXIT: begin
                is_return = 1'b1;
            end
            OP_ROTATE_LEFT_IN_PLACE: begin
                is_rotate = 1'b1;
                rot_left = 1'b1;
            end
            OP_ROTATE_LEFT_TO_ACCUMULATOR: begin
                is_rotate = 1'b1;
                rot_left = 1'b1;
                rot_to_wreg = 1'b1;
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
                is_rotate = 1'b1;
                rot_left = 1'b1;
                rot_thru = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR: begin
                is_rotate = 1'b1;
                rot_left = 1'b1;
                rot_thru = 1'b1;
                rot_to_wreg = 1'b1;
            end
            OP_ROTATE_RIGHT_IN_PLACE: begin
                is_rotate = 1'b1;
            end
            OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
                is_rotate = 1'b1;
                rot_to_wreg = 1'b1;
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                is_rotate = 1'b1;
                rot_thru = 1'b1;
            end
            default: begin
                known_op = 1'b0;
            end
        endcase
    end

    // Shared rotator; the operand is the memory byte the core fetched.
    byte_rotator u_rotator (
        .data_i(op_req_i.mem_data),
        .carry_i(op_req_i.carry),
        .left_i(rot_left),
        .thru_carry_i(rot_thru),
        .data_o(rot_data),
        .carry_o(rot_carry)
    );

    // Completion and error pulses, one cycle after the operation is taken.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            done_q <= op_valid_i && known_op && op_req_i.op != OP_IDLE;
            illegal_q <= op_valid_i && !known_op;
        end
    end

    // Program counter restore and stack pop for all three exits.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pc_load_q <= 1'b0;
            pc_q <= PC_RESET;
            stack_pop_q <= 1'b0;
        end else begin
            pc_load_q <= op_valid_i && is_return; // RQ1 RQ2 RQ3
            stack_pop_q <= op_valid_i && is_return; // RQ1 RQ2 RQ3
            if (op_valid_i && is_return) begin
                pc_q <= op_req_i.stack_top; // RQ1 RQ2 RQ3
            end
        end
    end

    // Only the interrupt exit raises the global enable.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gie_set_q <= 1'b0;
        end else begin
            gie_set_q <= op_valid_i
                && op_req_i.op == OP_INTERRUPT_EXIT; // RQ3
        end
    end

    // Working register: the literal exit and the to-register rotates.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wreg_we_q <= 1'b0;
            wreg_q <= BYTE_RESET;
        end else begin
            wreg_we_q <= 1'b0;
            if (op_valid_i
                && op_req_i.op == OP_SUBROUTINE_EXIT_WITH_LITERAL) begin
                wreg_we_q <= 1'b1;
                wreg_q <= op_req_i.imm; // RQ2
            end else if (op_valid_i && is_rotate && rot_to_wreg) begin
                wreg_we_q <= 1'b1;
                wreg_q <= rot_data; // RQ5 RQ7 RQ9
            end
        end
    end

    // Memory write-back for the in-place rotates and the two through-carry rotates that target memory.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_we_q <= 1'b0;
            mem_wdata_q <= BYTE_RESET;
        end else begin
            // To-register rotates leave the memory byte untouched.
            mem_we_q <= op_valid_i && is_rotate && !rot_to_wreg; // RQ5 RQ9
            if (op_valid_i && is_rotate && !rot_to_wreg) begin
                mem_wdata_q <= rot_data; // RQ4 RQ6 RQ8 RQ10
            end
        end
    end

    // Carry is the only flag touched, and only through carry.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            carry_we_q <= 1'b0;
            carry_q <= 1'b0;
        end else begin
            carry_we_q <= op_valid_i && is_rotate && rot_thru; // RQ11
            if (op_valid_i && is_rotate && rot_thru) begin
                carry_q <= rot_carry; // RQ6 RQ7 RQ10
            end
        end
    end

    // Every output field is a flip-flop; this only packs them.
    assign res_o.done = done_q;
    assign res_o.illegal = illegal_q;
    assign res_o.pc_load = pc_load_q;
    assign res_o.pc = pc_q;
    assign res_o.stack_pop = stack_pop_q;
    assign res_o.gie_set = gie_set_q;
    assign res_o.wreg_we = wreg_we_q;
    assign res_o.wreg = wreg_q;
    assign res_o.mem_we = mem_we_q;
    assign res_o.mem_wdata = mem_wdata_q;
    assign res_o.carry_we = carry_we_q;
    assign res_o.carry = carry_q;

    // Checks tie results to the request one edge earlier; carry_hold_a ties carry_q to its own past value.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sub_exit_a: assert property ( // RQ1
        op_valid_i && op_req_i.op == OP_SUBROUTINE_EXIT
        |=> pc_load_q && stack_pop_q && !wreg_we_q && !gie_set_q
            && pc_q == $past(op_req_i.stack_top))
        else $error("Subroutine exit did not restore the counter.");

    lit_exit_a: assert property ( // RQ2
        op_valid_i && op_req_i.op == OP_SUBROUTINE_EXIT_WITH_LITERAL
        |=> pc_load_q && stack_pop_q && wreg_we_q
            && wreg_q == $past(op_req_i.imm)
            && pc_q == $past(op_req_i.stack_top))
        else $error("Literal exit lost the counter or the literal.");

    irq_exit_a: assert property ( // RQ3
        op_valid_i && op_req_i.op == OP_INTERRUPT_EXIT
        |=> gie_set_q && pc_load_q && stack_pop_q
            && pc_q == $past(op_req_i.stack_top))
        else $error("Interrupt exit did not set the global enable.");

    left_place_a: assert property ( // RQ4
        op_valid_i && op_req_i.op == OP_ROTATE_LEFT_IN_PLACE
        |=> mem_we_q && !wreg_we_q
            && mem_wdata_q == {$past(op_req_i.mem_data[6:0]),
                               $past(op_req_i.mem_data[7])})
        else $error("Left rotate in place wrote a wrong byte.");

    left_wreg_a: assert property ( // RQ5
        op_valid_i && op_req_i.op == OP_ROTATE_LEFT_TO_ACCUMULATOR
        |=> wreg_we_q && !mem_we_q
            && wreg_q == {$past(op_req_i.mem_data[6:0]),
                          $past(op_req_i.mem_data[7])})
        else $error("Left rotate to register is wrong.");

    left_carry_a: assert property ( // RQ6
        op_valid_i && op_req_i.op == OP_ROTATE_LEFT_THROUGH_CARRY
        |=> mem_we_q && carry_we_q
            && carry_q == $past(op_req_i.mem_data[7])
            && mem_wdata_q == {$past(op_req_i.mem_data[6:0]),
                               $past(op_req_i.carry)})
        else $error("Left rotate through carry is wrong.");

    left_cwreg_a: assert property ( // RQ7
        op_valid_i && op_req_i.op == OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR
        |=> wreg_we_q && !mem_we_q && carry_we_q
            && carry_q == $past(op_req_i.mem_data[7])
            && wreg_q == {$past(op_req_i.mem_data[6:0]),
                          $past(op_req_i.carry)})
        else $error("Left carry rotate to register is wrong.");

    right_place_a: assert property ( // RQ8
        op_valid_i && op_req_i.op == OP_ROTATE_RIGHT_IN_PLACE
        |=> mem_we_q && !wreg_we_q
            && mem_wdata_q == {$past(op_req_i.mem_data[0]),
                               $past(op_req_i.mem_data[7:1])})
        else $error("Right rotate in place wrote a wrong byte.");

    right_wreg_a: assert property ( // RQ9
        op_valid_i && op_req_i.op == OP_ROTATE_RIGHT_TO_ACCUMULATOR
        |=> wreg_we_q && !mem_we_q
            && wreg_q == {$past(op_req_i.mem_data[0]),
                          $past(op_req_i.mem_data[7:1])})
        else $error("Right rotate to register is wrong.");

    right_carry_a: assert property ( // RQ10
        op_valid_i && op_req_i.op == OP_ROTATE_RIGHT_THROUGH_CARRY
        |=> mem_we_q && carry_we_q
            && carry_q == $past(op_req_i.mem_data[0])
            && mem_wdata_q == {$past(op_req_i.carry),
                               $past(op_req_i.mem_data[7:1])})
        else $error("Right rotate through carry is wrong.");

    carry_only_a: assert property ( // RQ11
        carry_we_q |-> $past(op_valid_i) && ($past(op_req_i.op)
            inside {OP_ROTATE_LEFT_THROUGH_CARRY,
                    OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR,
                    OP_ROTATE_RIGHT_THROUGH_CARRY}))
        else $error("Carry written by an operation that may not.");

    carry_hold_a: assert property ( // RQ11
        !carry_we_q |-> carry_q == $past(carry_q))
        else $error("Carry output changed without a carry write.");

    // A refused code may only raise the error pulse; nothing is written,
    // so a corrupted fetch cannot disturb the core's state.
    refused_op_a: assert property ( // RQ11
        op_valid_i && !known_op
        |=> illegal_q && !done_q && !pc_load_q && !wreg_we_q
            && !mem_we_q && !carry_we_q && !gie_set_q)
        else $error("Refused code wrote core state.");

    // Main scenarios worth seeing at least once.
    irq_exit_c: cover property (
        op_valid_i && op_req_i.op == OP_INTERRUPT_EXIT ##1 gie_set_q);

    carry_rot_c: cover property (
        op_valid_i && op_req_i.op == OP_ROTATE_RIGHT_THROUGH_CARRY
        ##1 carry_we_q && carry_q);

    lit_exit_c: cover property (
        op_valid_i && op_req_i.op == OP_SUBROUTINE_EXIT_WITH_LITERAL
        ##1 wreg_we_q && pc_load_q);

    back_to_back_c: cover property (
        op_valid_i && is_rotate && !rot_to_wreg
        ##1 op_valid_i && is_return && mem_we_q && !pc_load_q
        ##1 pc_load_q && !mem_we_q);

endmodule // return_and_rotate_exec

// *** verification/return_and_rotate_exec_tb.sv ***
`timescale 1ns/100ps
// Self-checking bench for the return and rotate execution slice.
module return_and_rotate_exec_tb
    import exec_pkg::*;
();
    logic clk_i;
    logic sys_rst_i;
    logic op_valid_i;
    exec_req_t op_req_i;
    exec_res_t res_o;
    int n_errors;
    int checked;
    // Expected held values; updated only when a write of that kind occurs.
    logic [PC_WIDTH-1:0] e_pc;
    logic [DATA_WIDTH-1:0] e_wreg;
    logic [DATA_WIDTH-1:0] e_mem;
    logic e_carry;

    return_and_rotate_exec dut (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .op_valid_i(op_valid_i),
        .op_req_i(op_req_i),
        .res_o(res_o)
    );

    // Free-running core clock, 4 ns period.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // One comparison; four-state equality so an unknown never matches.
    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Drives one cycle at a falling edge, then judges every output field
    // one cycle later, where the registered answer has settled.
    task automatic run_op(input logic [3:0] code, input logic v,
                          input logic [7:0] imm, input logic [7:0] m,
                          input logic c, input logic [11:0] stk);
        logic legal;
        logic ret;
        logic wr_w;
        logic wr_m;
        logic wr_c;
        logic nc;
        logic [7:0] r;
        op_valid_i = v;
        op_req_i.op = op_t'(code);
        op_req_i.imm = imm;
        op_req_i.mem_data = m;
        op_req_i.carry = c;
        op_req_i.stack_top = stk;
        legal = v && code >= 4'h1 && code <= 4'ha;
        ret = legal && code <= 4'h3;
        nc = c;
        case (code)
            4'h4, 4'h5: r = {m[6:0], m[7]};
            4'h6, 4'h7: begin
                r = {m[6:0], c};
                nc = m[7];
            end
            4'h8, 4'h9: r = {m[0], m[7:1]};
            4'ha: begin
                r = {c, m[7:1]};
                nc = m[0];
            end
            default: r = m;
        endcase
        wr_w = legal && (code == 4'h2 || code == 4'h5 || code == 4'h7 ||
                         code == 4'h9);
        wr_m = legal && (code == 4'h4 || code == 4'h6 || code == 4'h8 ||
                         code == 4'ha);
        wr_c = legal && (code == 4'h6 || code == 4'h7 || code == 4'ha);
        if (ret) e_pc = stk;
        if (wr_w) e_wreg = (code == 4'h2) ? imm : r;
        if (wr_m) e_mem = r;
        if (wr_c) e_carry = nc;
        @(negedge clk_i);
        check("done", 16'(legal), 16'(res_o.done));
        check("illegal", 16'(v && code > 4'ha), 16'(res_o.illegal));
        check("pc_load", 16'(ret), 16'(res_o.pc_load));
        check("stack_pop", 16'(ret), 16'(res_o.stack_pop));
        check("pc", 16'(e_pc), 16'(res_o.pc));
        check("gie_set", 16'(legal && code == 4'h3),
              16'(res_o.gie_set));
        check("wreg_we", 16'(wr_w), 16'(res_o.wreg_we));
        check("wreg", 16'(e_wreg), 16'(res_o.wreg));
        check("mem_we", 16'(wr_m), 16'(res_o.mem_we));
        check("mem_wdata", 16'(e_mem), 16'(res_o.mem_wdata));
        check("carry_we", 16'(wr_c), 16'(res_o.carry_we));
        check("carry", 16'(e_carry), 16'(res_o.carry));
    endtask

    // Holds reset three cycles and checks the values seen after release.
    task automatic do_reset();
        sys_rst_i = 1'b1;
        op_valid_i = 1'b0;
        e_pc = PC_RESET;
        e_wreg = BYTE_RESET;
        e_mem = BYTE_RESET;
        e_carry = 1'b0;
        repeat (3) @(negedge clk_i);
        sys_rst_i = 1'b0;
        run_op(4'h0, 1'b0, 8'h00, 8'h00, 1'b0, 12'h000);
    endtask

    // All three returns back to back, then the strobes must drop.
    task automatic test_returns();
        run_op(4'h1, 1'b1, 8'h77, 8'h3c, 1'b1, 12'hfff);
        run_op(4'h2, 1'b1, 8'ha5, 8'h3c, 1'b1, 12'h001);
        run_op(4'h3, 1'b1, 8'h5a, 8'h00, 1'b0, 12'h123);
        run_op(4'h0, 1'b0, 8'h00, 8'h00, 1'b0, 12'h000);
    endtask

    // Every rotate on edge patterns with both carry values, back to back,
    // then a return straight after the last write-back rotate.
    task automatic test_rotates();
        logic [7:0] pats [4];
        pats = '{8'h81, 8'h01, 8'h80, 8'h5a};
        for (int code = 4; code <= 10; code++) begin
            for (int c = 0; c < 2; c++) begin
                foreach (pats[i]) begin
                    run_op(4'(code), 1'b1, 8'hc3, pats[i], 1'(c),
                           12'h456);
                end
            end
        end
        run_op(4'h1, 1'b1, 8'h00, 8'h00, 1'b0, 12'h7ff);
        run_op(4'h0, 1'b0, 8'h00, 8'h00, 1'b0, 12'h000);
    endtask

    // Idle, unknown codes and a rotate without valid must write nothing.
    task automatic test_refused();
        run_op(4'h0, 1'b1, 8'hff, 8'hff, 1'b1, 12'hfff);
        for (int code = 11; code <= 15; code++) begin
            run_op(4'(code), 1'b1, 8'hff, 8'h81, 1'b1, 12'hfff);
        end
        run_op(4'h6, 1'b0, 8'hff, 8'h81, 1'b1, 12'hfff);
    endtask

    // Reset in mid-run clears results at once, without a clock edge.
    // The interrupt exit first sets pc and the enable pulse, so the
    // checks below can only pass if the reset really cleared them.
    task automatic test_mid_reset();
        run_op(4'h3, 1'b1, 8'h00, 8'h00, 1'b0, 12'h9ab);
        op_valid_i = 1'b0;
        sys_rst_i = 1'b1;
        #1;
        check("rst_done", 16'h0000, 16'(res_o.done));
        check("rst_pc", 16'(PC_RESET), 16'(res_o.pc));
        check("rst_gie", 16'h0000, 16'(res_o.gie_set));
        do_reset();
        run_op(4'ha, 1'b1, 8'h00, 8'h01, 1'b1, 12'h000);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The whole sequence needs about 80 cycles; 2000 means a hang.
    initial begin
        repeat (2000) @(posedge clk_i);
        n_errors++;
        summarize();
    end

    initial begin
        n_errors = 0;
        checked = 0;
        op_req_i = '0;
        do_reset();
        test_returns();
        test_rotates();
        test_refused();
        test_mid_reset();
        summarize();
    end
endmodule // return_and_rotate_exec_tb
